/* File: shared/sscf_pkg.sv */
// sscf_pkg: constants, register map and carrier types of the sync/crc framer.
// assumes one 125 MHz core clock; the serializer word clock arrives asynchronously.
`default_nettype none
package sscf_pkg;
  localparam int unsigned  LANES      = 8;
  localparam int unsigned  PW         = 10;        // pixel / word width
  localparam int unsigned  GRP_PIX    = 32;        // widest pixel group (two 16-pixel units)
  localparam int unsigned  CLK_MHZ    = 125;

  // register map (word addresses of the register port)
  localparam logic [7:0]   ADR_TRAIN  = 8'h82;
  localparam logic [7:0]   ADR_SYNCID = 8'h83;
  localparam logic [7:0]   ADR_BLACK  = 8'h84;
  localparam logic [7:0]   ADR_IMAGE  = 8'h85;
  localparam logic [7:0]   ADR_CHECK  = 8'h86;
  localparam logic [7:0]   ADR_TRCLS  = 8'h87;
  localparam logic [7:0]   ADR_CTRL   = 8'h88;
  localparam logic [7:0]   ADR_STAT   = 8'h89;
  localparam logic [7:0]   ADR_IDENT  = 8'h8A;

  localparam logic [9:0]   RST_TRAIN  = 10'h3A6;
  localparam logic [6:0]   RST_SYNCID = 7'h2A;
  localparam logic [9:0]   RST_BLACK  = 10'h015;
  localparam logic [9:0]   RST_IMAGE  = 10'h035;
  localparam logic [9:0]   RST_CHECK  = 10'h059;
  localparam logic [9:0]   RST_TRCLS  = 10'h3A6;
  localparam logic [3:0]   RST_CTRL   = 4'h0;
  localparam logic [9:0]   IDENT_VAL  = 10'h1C3;   // arbitrary value, names no part

  // control register fields
  localparam int unsigned  CTL_EIGHT  = 0;
  localparam int unsigned  CTL_SUB    = 1;
  localparam int unsigned  CTL_COLOR  = 2;
  localparam int unsigned  CTL_SEED   = 3;

  // boundary type codes, top three bits of a sync word
  localparam logic [2:0]   TYP_FRAME_BEGIN  = 3'h5;
  localparam logic [2:0]   TYP_FRAME_FINISH = 3'h6;
  localparam logic [2:0]   TYP_LINE_BEGIN   = 3'h1;
  localparam logic [2:0]   TYP_LINE_FINISH  = 3'h2;

  // check code generators, leading term implied
  localparam logic [9:0]   CRC10_POLY = 10'h24F;
  localparam logic [7:0]   CRC8_POLY  = 8'h4D;

  typedef enum {ST_IDLE, ST_BEGIN, ST_BEGIN_ID, ST_DATA, ST_FINISH, ST_FINISH_ID, ST_CHECK}
    sscf_state_e;

  typedef struct packed {
    logic       first;     // first line of the window: frame begin code
    logic       last;      // last line: frame finish code
    logic       dark;      // dark pixel line
    logic [7:0] win_act;   // active readout windows on this line
    logic [8:0] groups;    // pixel groups in the line
  } sscf_line_s;

  typedef struct packed {
    logic                         odd;  // odd positioned kernel pair
    logic [GRP_PIX-1:0][PW-1:0]   px;   // pixel 0 in the low slot
  } sscf_group_s;

  typedef logic [LANES-1:0][PW-1:0] sscf_lanes_t;
endpackage
`default_nettype wire

/* File: logic/sscf_framer.sv */
// sscf_framer: sync channel words, lane training, per-lane check codes, pixel order.
// assumes line and pixel requests from same-clock logic; word clock from the serializer.
`timescale 1ns/100ps
`default_nettype none
module sscf_framer
  import sscf_pkg::*;
(
  input  wire logic        clk,           // core clock
  input  wire logic        rst,           // async reset, high
  input  wire logic        word_clk,      // serializer word clock, asynchronous
  input  wire logic        reg_wr,        // register write strobe
  input  wire logic        reg_rd,        // register read strobe
  input  wire logic [7:0]  reg_addr,      // register address
  input  wire logic [9:0]  reg_wdata,     // register write data
  output logic      [9:0]  reg_rdata,     // register read data
  input  wire logic        line_req,      // a line is waiting
  input  wire sscf_line_s  line_info,     // its description
  output logic             line_ack,      // line taken, one cycle
  input  wire logic        pix_valid,     // a pixel group is waiting
  input  wire sscf_group_s pix_group,     // the group
  output logic             pix_ready,     // group taken, one cycle
  output sscf_lanes_t      lane_word,     // data lane words
  output logic      [9:0]  sync_word,     // sync lane word
  output logic             word_stb       // new words presented, one cycle
);
  logic [9:0]  train_ff, black_ff, image_ff, check_ff, trcls_ff;
  logic [6:0]  syncid_ff;
  logic [3:0]  ctrl_ff;
  logic [2:0]  wclk_ff;
  logic        tick;
  sscf_state_e st_ff;
  sscf_line_s  line_ff;
  sscf_group_s grp_ff;
  logic        word_idx_ff;
  logic [8:0]  left_ff;
  logic [9:0]  crc_ff [LANES];
  logic        eight, sub, color;
  logic [2:0]  win_id;
  logic [9:0]  seed, trn_w, cls_dark, cls_img, cls_chk, cls_tr, code_w, id_w;
  logic        last_word;

  // registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      train_ff  <= RST_TRAIN;
      syncid_ff <= RST_SYNCID;
      black_ff  <= RST_BLACK;
      image_ff  <= RST_IMAGE;
      check_ff  <= RST_CHECK;
      trcls_ff  <= RST_TRCLS;
      ctrl_ff   <= RST_CTRL;
    end else if (reg_wr) begin
      case (reg_addr)
        ADR_TRAIN:  train_ff  <= reg_wdata;
        ADR_SYNCID: syncid_ff <= reg_wdata[6:0];
        ADR_BLACK:  black_ff  <= reg_wdata;
        ADR_IMAGE:  image_ff  <= reg_wdata;
        ADR_CHECK:  check_ff  <= reg_wdata;
        ADR_TRCLS:  trcls_ff  <= reg_wdata;
        ADR_CTRL:   ctrl_ff   <= reg_wdata[3:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 10'h000;
    end else if (reg_rd) begin
      case (reg_addr)
        ADR_TRAIN:  reg_rdata <= train_ff;
        ADR_SYNCID: reg_rdata <= {3'h0, syncid_ff};
        ADR_BLACK:  reg_rdata <= black_ff;
        ADR_IMAGE:  reg_rdata <= image_ff;
        ADR_CHECK:  reg_rdata <= check_ff;
        ADR_TRCLS:  reg_rdata <= trcls_ff;
        ADR_CTRL:   reg_rdata <= {6'h00, ctrl_ff};
        ADR_STAT:   reg_rdata <= {left_ff, st_ff != ST_IDLE};
        ADR_IDENT:  reg_rdata <= IDENT_VAL;
        default:    reg_rdata <= 10'h000;
      endcase
    end
  end

  // word clock: two stages before use, third only for the edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wclk_ff <= 3'h0;
    end else begin
      wclk_ff <= {wclk_ff[1:0], word_clk};
    end
  end
  assign tick = wclk_ff[1] & ~wclk_ff[2];

  assign eight = ctrl_ff[CTL_EIGHT];
  assign sub   = ctrl_ff[CTL_SUB];
  assign color = ctrl_ff[CTL_COLOR];

  // highest active window wins; same choice in both word modes
  function automatic logic [2:0] top_win(input logic [7:0] act);
    logic [2:0] id;
    id = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (act[i]) id = 3'(i);
    end
    return id;
  endfunction
  assign win_id = top_win(line_ff.win_act);

  // mode dependent words; the 8-bit forms drop the two low register bits
  function automatic logic [9:0] narrow(input logic [9:0] r, input logic e);
    return e ? {2'h0, r[9:2]} : r;
  endfunction
  assign trn_w    = narrow(train_ff, eight);
  assign cls_dark = narrow(black_ff, eight);
  assign cls_img  = narrow(image_ff, eight);
  assign cls_chk  = narrow(check_ff, eight);
  assign cls_tr   = narrow(trcls_ff, eight);

  always_comb begin
    logic [2:0] typ;
    typ = 3'h0;
    if (st_ff == ST_IDLE || st_ff == ST_BEGIN) begin
      typ = line_ff.first ? TYP_FRAME_BEGIN : TYP_LINE_BEGIN;
    end else begin
      typ = line_ff.last ? TYP_FRAME_FINISH : TYP_LINE_FINISH;
    end
    if (eight) begin
      code_w = {2'h0, typ, syncid_ff[6:2]};
      id_w   = {5'h00, win_id, 2'h0};
    end else begin
      code_w = {typ, syncid_ff};
      id_w   = {7'h00, win_id};
    end
  end

  assign seed = ctrl_ff[CTL_SEED] ? (eight ? 10'h0FF : 10'h3FF) : 10'h000;

  // one word step of a lane's check code, msb first
  function automatic logic [9:0] crc_next(input logic [9:0] c_in, input logic [9:0] d,
                                          input logic e);
    logic [9:0] c;
    logic       fb;
    c  = c_in;
    fb = 1'b0;
    for (int i = 9; i >= 0; i--) begin
      if (e) begin
        if (i < 8) begin
          fb = d[i] ^ c[7];
          c  = {2'h0, c[6:0], 1'b0} ^ (fb ? {2'h0, CRC8_POLY} : 10'h000);
        end
      end else begin
        fb = d[i] ^ c[9];
        c  = {c[8:0], 1'b0} ^ (fb ? CRC10_POLY : 10'h000);
      end
    end
    return c;
  endfunction

  // position inside the 32-pixel group for lane c, word w
  function automatic logic [4:0] pix_idx(input logic [2:0] c, input logic w, input logic s,
                                         input logic col, input logic odd);
    if (s && col) begin
      return {1'b0, c[2:1], 1'b0, c[0]};
    end else if (s) begin
      return {c, w, 1'b0};
    end else if (odd) begin
      return 5'h0F - {1'b0, c, w};
    end
    return {1'b0, c, w};
  endfunction

  // colour subsampling gives one word per group, the others two
  assign last_word = (sub && color) ? 1'b1 : word_idx_ff;

  // sequencer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff       <= ST_IDLE;
      line_ff     <= '0;
      left_ff     <= 9'h000;
      word_idx_ff <= 1'b0;
      line_ack    <= 1'b0;
      pix_ready   <= 1'b0;
      grp_ff      <= '0;
    end else begin
      line_ack  <= 1'b0;
      pix_ready <= 1'b0;
      if (tick) begin
        case (st_ff)
          ST_IDLE: begin
            if (line_req) begin
              line_ff  <= line_info;
              left_ff  <= line_info.groups;
              line_ack <= 1'b1;
              st_ff    <= ST_BEGIN;
            end
          end
          ST_BEGIN:    st_ff <= ST_BEGIN_ID;
          ST_BEGIN_ID: begin
            word_idx_ff <= 1'b0;
            st_ff       <= (left_ff == 9'h000) ? ST_FINISH : ST_DATA;
          end
          ST_DATA: begin
            if (word_idx_ff || pix_valid) begin
              if (!word_idx_ff) begin
                grp_ff    <= pix_group;
                pix_ready <= 1'b1;
              end
              if (last_word) begin
                word_idx_ff <= 1'b0;
                left_ff     <= left_ff - 9'h001;
                if (left_ff == 9'h001) st_ff <= ST_FINISH;
              end else begin
                word_idx_ff <= 1'b1;
              end
            end
          end
          ST_FINISH:    st_ff <= ST_FINISH_ID;
          ST_FINISH_ID: st_ff <= ST_CHECK;
          ST_CHECK:     st_ff <= ST_IDLE;
          default:      st_ff <= ST_IDLE;
        endcase
      end
    end
  end

  // lanes and check codes in one generate slice per lane, then the sync word
  sscf_group_s cur_grp;
  logic        data_now;
  assign cur_grp  = word_idx_ff ? grp_ff : pix_group;
  assign data_now = (st_ff == ST_DATA) && (word_idx_ff || pix_valid);

  for (genvar g = 0; g < LANES; g++) begin : g_lane
    logic [9:0] pix_w;
    always_comb begin
      pix_w = cur_grp.px[pix_idx(3'(g), word_idx_ff, sub, color, cur_grp.odd)];
      if (eight) pix_w = {2'h0, pix_w[9:2]};
    end
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        crc_ff[g]    <= 10'h000;
        lane_word[g] <= RST_TRAIN;
      end else if (tick) begin
        if (st_ff == ST_BEGIN) begin
          crc_ff[g] <= seed;
        end else if (data_now) begin
          crc_ff[g] <= crc_next(crc_ff[g], pix_w, eight);
        end
        if (data_now) begin
          lane_word[g] <= pix_w;
        end else if (st_ff == ST_CHECK) begin
          lane_word[g] <= crc_ff[g];
        end else begin
          lane_word[g] <= trn_w;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_word <= RST_TRCLS;
      word_stb  <= 1'b0;
    end else begin
      word_stb <= tick;
      if (tick) begin
        case (st_ff)
          ST_BEGIN, ST_FINISH:       sync_word <= code_w;
          ST_BEGIN_ID, ST_FINISH_ID: sync_word <= id_w;
          ST_CHECK:                  sync_word <= cls_chk;
          ST_DATA: begin
            if (data_now) sync_word <= line_ff.dark ? cls_dark : cls_img;
            else          sync_word <= cls_tr;
          end
          default:                   sync_word <= cls_tr;
        endcase
      end
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  idle_training_a: assert property ((tick && st_ff == ST_IDLE) |=>
      lane_word[3] == $past(trn_w) && sync_word == $past(cls_tr))
    else $error("idle words are not training");
  train_eight_a: assert property ((tick && st_ff == ST_IDLE && eight) |=>
      lane_word[0] == {2'h0, $past(train_ff[9:2])})
    else $error("8-bit training pattern wrong");
  type_eight_a: assert property ((tick && st_ff == ST_BEGIN && eight) |=>
      sync_word[7:5] == ($past(line_ff.first) ? 3'h5 : 3'h1) && sync_word[9:8] == 2'h0)
    else $error("8-bit begin code type wrong");
  ident_eight_a: assert property ((tick && st_ff == ST_FINISH && eight) |=>
      sync_word[4:0] == $past(syncid_ff[6:2]))
    else $error("8-bit sync identifier wrong");
  window_word_a: assert property ((tick && st_ff == ST_BEGIN_ID && eight) |=>
      sync_word == {5'h00, $past(win_id), 2'h0})
    else $error("window word wrong");
  check_sync_a: assert property ((tick && st_ff == ST_CHECK) |=>
      sync_word == $past(cls_chk) && lane_word[7] == $past(crc_ff[7]) ##1 st_ff == ST_IDLE)
    else $error("check word cycle wrong");
  crc_seed_a: assert property ((tick && st_ff == ST_BEGIN) |=> crc_ff[2] == $past(seed))
    else $error("check code not reseeded");
  crc_hold_a: assert property ((tick && st_ff == ST_DATA && !data_now) |=>
      crc_ff[5] == $past(crc_ff[5]))
    else $error("idle word entered check code");
  pix_take_a: assert property (pix_ready |-> $past(pix_valid) && !line_ack ##1 !pix_ready)
    else $error("group taken without valid");

  eight_line_c: cover property (tick && st_ff == ST_CHECK && eight);
  color_sub_c:  cover property (pix_ready && sub && color);
  odd_kernel_c: cover property (pix_ready && !sub && pix_group.odd);
endmodule
`default_nettype wire

/* File: sim/sscf_rx_model.sv */
// sscf_rx_model: receiver side of the framer, records sync words and checks lane codes.
// assumes the bench tells it the class words and word mode in force for the line.
`timescale 1ns/100ps
`default_nettype none
module sscf_rx_model
  import sscf_pkg::*;
(
  input wire logic        clk,        // core clock
  input wire logic        rst,        // async reset, high
  input wire logic        word_stb,   // new words presented
  input wire sscf_lanes_t lane_word,  // data lane words
  input wire logic [9:0]  sync_word,  // sync lane word
  input wire logic        eight,      // eight-bit word mode
  input wire logic        seed,       // all-one check seed
  input wire logic [9:0]  data_cls,   // class word of this line's data
  input wire logic [9:0]  chk_cls,    // check class word
  input wire logic [9:0]  tr_cls      // training class word
);
  logic [9:0]  crc [LANES];
  logic        in_data;
  int          crc_good;
  int          crc_bad;
  int          n_chk;
  logic [89:0] seen_q[$];

  // bitwise, msb first; kept apart from any design arithmetic
  function automatic logic [9:0] step(logic [9:0] c, logic [9:0] d, logic e);
    logic fb;
    for (int b = 9; b >= 0; b--) begin
      if (!(e && b > 7)) begin
        fb = (e ? c[7] : c[9]) ^ d[b];
        c = e ? {2'b00, c[6:0], 1'b0} : {c[8:0], 1'b0};
        if (fb) c = c ^ (e ? 10'h04D : 10'h24F);
      end
    end
    return c;
  endfunction

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      in_data = 1'b0;
      crc_good = 0;
      crc_bad = 0;
      n_chk = 0;
      for (int c = 0; c < LANES; c++) crc[c] = 10'h000;
    end else if (word_stb) begin
      if (sync_word !== tr_cls) seen_q.push_back({sync_word, lane_word});
      if (sync_word === data_cls) begin
        in_data = 1'b1;
        for (int c = 0; c < LANES; c++) crc[c] = step(crc[c], lane_word[c], eight);
      end else if (sync_word === chk_cls) begin
        n_chk++;
        in_data = 1'b0;
        for (int c = 0; c < LANES; c++) begin
          if (lane_word[c] === crc[c]) crc_good++;
          else crc_bad++;
        end
      end else if (!in_data) begin
        // idle words only reseed before data; a gap mid-line must not
        for (int c = 0; c < LANES; c++) crc[c] = seed ? (eight ? 10'h0FF : 10'h3FF) : 10'h000;
      end
    end
  end
endmodule
`default_nettype wire

/* File: sim/sscf_framer_bench.sv */
// sscf_framer_bench: register, framing, pixel order and check code tests of the framer.
// assumes a free running word clock; the receiver model judges check codes.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin miscompares++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module sscf_framer_bench
  import sscf_pkg::*;
;
  logic        clk = 1'b0, rst = 1'b1, word_clk = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        line_req = 1'b0, pix_valid = 1'b0, line_ack, pix_ready, word_stb;
  logic [7:0]  reg_addr = 8'h00;
  logic [9:0]  reg_wdata = 10'h000, reg_rdata, sync_word, d;
  sscf_line_s  line_info = '0;
  sscf_group_s pix_group = '0;
  sscf_group_s grp [2];
  sscf_lanes_t lane_word;
  logic        eight = 1'b0, sub = 1'b0, col = 1'b0, seed = 1'b0;
  logic [6:0]  sid = 7'h2A;
  logic [9:0]  trn = 10'h3A6, valid_pixel_class = 10'h035, blk = 10'h015, chkc = 10'h059, trc = 10'h3A6;
  logic [9:0]  data_cls = 10'h035, tr_cls = 10'h3A6, chk_cls = 10'h059;
  logic [90:0] exp_q[$];
  int          miscompares = 0, total_checks = 0;
  logic [7:0]  ra [10] = '{8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87, 8'h88, 8'h89, 8'h8A,
                           8'h90};
  logic [9:0]  rv [10] = '{10'h3A6, 10'h02A, 10'h015, 10'h035, 10'h059, 10'h3A6, 10'h000,
                           10'h000, IDENT_VAL, 10'h000};

  always #4 clk = ~clk;
  always #32 word_clk = ~word_clk;

  sscf_framer uut (.clk(clk), .rst(rst), .word_clk(word_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .line_req(line_req),
    .line_info(line_info), .line_ack(line_ack), .pix_valid(pix_valid), .pix_group(pix_group),
    .pix_ready(pix_ready), .lane_word(lane_word), .sync_word(sync_word), .word_stb(word_stb));
  sscf_rx_model rx (.clk(clk), .rst(rst), .word_stb(word_stb), .lane_word(lane_word),
    .sync_word(sync_word), .eight(eight), .seed(seed), .data_cls(data_cls),
    .chk_cls(chk_cls), .tr_cls(tr_cls));

  function automatic logic [9:0] sc(logic [9:0] v);
    return eight ? {2'b00, v[9:2]} : v;
  endfunction
  function automatic logic [9:0] cd(logic [2:0] t);
    return eight ? {2'b00, t, sid[6:2]} : {t, sid};
  endfunction
  function automatic logic [9:0] px_at(sscf_group_s g, int c, int w);
    int i;
    if (sub && col) i = (c / 2) * 4 + c % 2;
    else if (sub) i = 4 * c + 2 * w;
    else if (g.odd) i = 15 - 2 * c - w;
    else i = 2 * c + w;
    return sc(g.px[i]);
  endfunction

  task automatic wr(input logic [7:0] a, input logic [9:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [9:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    v = reg_rdata;
  endtask
  task automatic mode(input logic e, input logic s, input logic cl, input logic sd);
    eight = e;
    sub = s;
    col = cl;
    seed = sd;
    wr(8'h88, {6'h00, sd, cl, s, e});
  endtask

  task automatic run_line(input sscf_line_s li, input string nm);
    sscf_lanes_t ln, tl;
    logic [9:0]  wn;
    logic [90:0] e;
    logic [2:0]  win;
    int          k, g, w, c, good, n0;
    @(negedge clk);
    win = 3'h0;
    for (k = 0; k < 8; k++) if (li.win_act[k]) win = 3'(k);
    wn = eight ? {5'b00000, win, 2'b00} : {7'h00, win};
    data_cls = sc(li.dark ? blk : valid_pixel_class);
    tr_cls = sc(trc);
    chk_cls = sc(chkc);
    for (c = 0; c < 8; c++) tl[c] = sc(trn);
    exp_q.delete();
    exp_q.push_back({1'b1, cd(li.first ? TYP_FRAME_BEGIN : TYP_LINE_BEGIN), tl});
    exp_q.push_back({1'b1, wn, tl});
    for (g = 0; g < li.groups; g++)
      for (w = 0; w < ((sub && col) ? 1 : 2); w++) begin
        for (c = 0; c < 8; c++) ln[c] = px_at(grp[g], c, w);
        exp_q.push_back({1'b1, data_cls, ln});
      end
    exp_q.push_back({1'b1, cd(li.last ? TYP_FRAME_FINISH : TYP_LINE_FINISH), tl});
    exp_q.push_back({1'b1, wn, tl});
    exp_q.push_back({1'b0, chk_cls, tl});
    rx.seen_q.delete();
    good = rx.crc_good;
    n0 = rx.n_chk;
    @(posedge clk);
    line_info <= li;
    line_req <= 1'b1;
    for (k = 0; k < 500 && line_ack !== 1'b1; k++) @(posedge clk);
    line_req <= 1'b0;
    `CHK("line taken", 1'b1, line_ack)
    for (g = 0; g < li.groups; g++) begin
      pix_group <= grp[g];
      pix_valid <= 1'b1;
      @(posedge clk);
      for (k = 0; k < 500 && pix_ready !== 1'b1; k++) @(posedge clk);
      `CHK("group taken", 1'b1, pix_ready)
      // gap over two word ticks puts idle words inside the line
      pix_valid <= 1'b0;
      repeat (20) @(posedge clk);
    end
    for (k = 0; k < 3000 && rx.n_chk == n0; k++) @(posedge clk);
    `CHK("check word seen", n0 + 1, rx.n_chk)
    @(posedge clk);
    for (k = 0; k < 100 && word_stb !== 1'b1; k++) @(posedge clk);
    `CHK("word strobe", 1'b1, word_stb)
    `CHK("idle sync", sc(trc), sync_word)
    `CHK("idle lanes", tl, lane_word)
    `CHK("word count", exp_q.size(), rx.seen_q.size())
    for (k = 0; k < exp_q.size() && k < rx.seen_q.size(); k++) begin
      e = exp_q[k];
      `CHK("sync word", e[89:80], rx.seen_q[k][89:80])
      if (e[90]) `CHK("lane words", e[79:0], rx.seen_q[k][79:0])
    end
    `CHK("good check codes", good + 8, rx.crc_good)
    `CHK("bad check codes", 0, rx.crc_bad)
    $display("test %s done", nm);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    #400000;
    miscompares++;
    final_report();
  end

  initial begin
    for (int g = 0; g < 2; g++) begin
      grp[g].odd = g[0];
      for (int i = 0; i < 32; i++) grp[g].px[i] = 10'((g * 37 + i * 29 + 5) % 1024);
    end
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      rd(ra[i], d);
      `CHK("register reset", rv[i], d)
    end
    wr(8'h8A, 10'h000);
    rd(8'h8A, d);
    `CHK("read only ident", IDENT_VAL, d)
    $display("test registers done");
    run_line('{1'b1, 1'b1, 1'b0, 8'h06, 9'd2}, "ten bit frame");
    mode(1'b1, 1'b1, 1'b0, 1'b1);
    wr(8'h83, 10'h055);
    sid = 7'h55;
    run_line('{1'b0, 1'b0, 1'b1, 8'h81, 9'd2}, "eight bit mono");
    mode(1'b1, 1'b1, 1'b1, 1'b0);
    wr(8'h82, 10'h155);
    trn = 10'h155;
    wr(8'h85, 10'h3FC);
    valid_pixel_class = 10'h3FC;
    run_line('{1'b1, 1'b1, 1'b0, 8'h01, 9'd1}, "eight bit colour");
    mode(1'b0, 1'b0, 1'b0, 1'b1);
    run_line('{1'b0, 1'b1, 1'b0, 8'h00, 9'd0}, "empty line");
    final_report();
  end
endmodule
`default_nettype wire
